// File: rtl/membus_consts.vh
// Constants for the multiplexed memory bus interface
// Behaviour
// R1 - Address phase with strobe, then data phase
// R2 - Reads take one datum or four words
// R3 - Byte lanes from size, port width, ordering
// R4 - Low address valid bits follow port width
// R5 - Single transfers start exact, step per piece
// R6 - Block reads count from zero by width
// R7 - Sample four options on low pins in reset
// R8 - Diagnostic shows cache miss in address phase
// R9 - Diagnostic shows instruction fetch in slot two
// R10 - Diagnostic undefined outside read cycles
// R11 - Latch strobe high while address on bus
// R12 - Memory latches address with the strobe
// R13 - Data enable only after device releases bus
// R14 - Memory drives bus only under data enable
// R15 - Data enable low on writes and idle
// R16 - Memory pulses capture with valid read data
// R17 - Memory acknowledges processed transactions
// R18 - Low address pins released during reset
`ifndef MEMBUS_CONSTS_VH
`define MEMBUS_CONSTS_VH
`define PORT_W32 2'h0
`define PORT_W16 2'h1
`define PORT_W8 2'h2
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define OPT_BOOT16_BIT 0
`define OPT_BOOT8_BIT 1
`define OPT_RSVD_HIGH_BIT 2
`define OPT_EXT_HOLD_BIT 3
`define BURST_WORDS 3'h4
`define FIFO_DEPTH 8
`define FIFO_AW 3
`endif

// File: rtl/rd_fifo.v
// Parameterised FIFO for read data
`timescale 1ns/1ps
module rd_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire reset_n,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr_reg;
	reg [AW:0] rd_ptr_reg;
	wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	wire empty = (wr_ptr_reg == rd_ptr_reg);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];
	always @(posedge clk) begin
		if (in_valid && !full)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= {(AW+1){1'b0}};
			rd_ptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (out_ready && !empty)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule

// File: rtl/membus_if.v
// Device side of the multiplexed address/data memory bus
`include "membus_consts.vh"
`timescale 1ns/1ps
module membus_if (
	// Clock and reset
	input wire CLK_SYS,
	input wire RESET_N,
	// Core request
	input wire REQ_VALID,
	output wire REQ_READY,
	input wire REQ_WRITE,
	input wire REQ_BURST,
	input wire [1:0] REQ_SIZE,
	input wire [31:0] REQ_ADDR,
	input wire [31:0] REQ_WDATA,
	input wire REQ_MISS,
	input wire REQ_IFETCH,
	input wire [1:0] PORT_WIDTH,
	input wire BIG_ENDIAN,
	// Read data to core
	output wire [31:0] RD_DATA,
	output wire RD_VALID,
	input wire RD_READY,
	output reg DONE,
	// Multiplexed bus
	input wire [31:0] AD_IN,
	output reg [31:0] AD_OUT,
	output reg AD_OE,
	input wire [3:0] ADDR_LO_IN,
	output reg [3:0] ADDR_LO_OUT,
	output wire ADDR_LO_OE,
	output reg ALE,
	output reg DIAG,
	output reg READ_DRIVE_ENABLE,
	output reg [3:0] LANES,
	// Memory handshake
	input wire READ_BUF_CAPTURE,
	input wire ACK,
	// Sampled options
	output reg BOOT_ROM_16BIT_OPT,
	output reg BOOT_ROM_8BIT_OPT,
	output reg RESERVED_HIGH_OPT,
	output reg EXTENDED_ADDR_HOLD_OPT
);
	localparam S_IDLE = 4'h1;
	localparam S_ADDR = 4'h2;
	localparam S_TURN = 4'h4;
	localparam S_DATA = 4'h8;

	////////////////////////////////////////////////////////////////
	reg [1:0] cap_meta_reg, cap_sync_reg, ack_meta_reg, ack_sync_reg;
	reg [3:0] lo_meta_reg, lo_sync_reg;
	reg [31:0] ad_meta_reg, ad_sync_reg;
	reg rst_seen_reg;
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cap_meta_reg <= 2'h0;
			cap_sync_reg <= 2'h0;
			ack_meta_reg <= 2'h0;
			ack_sync_reg <= 2'h0;
			ad_meta_reg <= 32'h0;
			ad_sync_reg <= 32'h0;
		end else begin
			cap_meta_reg <= {cap_meta_reg[0], READ_BUF_CAPTURE};
			cap_sync_reg <= {cap_sync_reg[0], cap_meta_reg[1]};
			ack_meta_reg <= {ack_meta_reg[0], ACK};
			ack_sync_reg <= {ack_sync_reg[0], ack_meta_reg[1]};
			ad_meta_reg <= AD_IN;
			ad_sync_reg <= ad_meta_reg;
		end
	end
	// Strap synchroniser runs through reset so the options see the pins
	always @(posedge CLK_SYS) begin
		lo_meta_reg <= ADDR_LO_IN; // R7
		lo_sync_reg <= lo_meta_reg;
	end
	// Newer stage high, older stage low: a rising pin
	wire cap_rise = cap_sync_reg[0] && !cap_sync_reg[1];
	wire ack_rise = ack_sync_reg[0] && !ack_sync_reg[1];

	////////////////////////////////////////////////////////////////
	// Option pins sampled on the second clock after reset, kept afterwards
	// Released pins in reset: the async clear leaves OE low
	assign ADDR_LO_OE = rst_seen_reg; // R18
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_seen_reg <= 1'b0;
		end else begin
			rst_seen_reg <= 1'b1;
		end
	end
	reg [1:0] opt_wait_reg;
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			opt_wait_reg <= 2'h0;
		end else if (opt_wait_reg != 2'h3) begin
			opt_wait_reg <= opt_wait_reg + 2'h1;
		end
	end
	// Synchroniser still holds pin levels captured before release
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			BOOT_ROM_16BIT_OPT <= 1'b0;
			BOOT_ROM_8BIT_OPT <= 1'b0;
			RESERVED_HIGH_OPT <= 1'b0;
			EXTENDED_ADDR_HOLD_OPT <= 1'b0;
		end else if (opt_wait_reg == 2'h1) begin
			BOOT_ROM_16BIT_OPT <= lo_sync_reg[`OPT_BOOT16_BIT]; // R7
			BOOT_ROM_8BIT_OPT <= lo_sync_reg[`OPT_BOOT8_BIT]; // R7
			RESERVED_HIGH_OPT <= lo_sync_reg[`OPT_RSVD_HIGH_BIT]; // R7
			EXTENDED_ADDR_HOLD_OPT <= lo_sync_reg[`OPT_EXT_HOLD_BIT]; // R7
		end
	end

	////////////////////////////////////////////////////////////////
	reg [3:0] state_reg;
	reg write_reg, burst_reg, miss_reg, ifetch_reg, big_reg;
	reg [1:0] size_reg, width_reg;
	reg [31:0] addr_reg, wdata_reg;
	reg [3:0] lo_reg;
	reg [3:0] pieces_reg;
	reg [31:0] asm_reg;
	wire fifo_in_ready;
	reg fifo_push;

	wire [3:0] step = (width_reg == `PORT_W32) ? 4'h4 :
		(width_reg == `PORT_W16) ? 4'h2 : 4'h1;
	wire [3:0] port_bytes = step;
	wire [3:0] datum_bytes = (size_reg == `SIZE_WORD) ? 4'h4 :
		(size_reg == `SIZE_HALF) ? 4'h2 : 4'h1;
	wire [3:0] datum_pieces = burst_reg ? 4'h1 :
		((datum_bytes > port_bytes) ? (datum_bytes / port_bytes) : 4'h1); // R5
	wire [1:0] bofs = big_reg ? (2'h3 - lo_reg[1:0]) : lo_reg[1:0];

	// Active byte lanes from datum size, port width and ordering
	always @* begin
		LANES = 4'h0; // R3
		if (width_reg == `PORT_W8)
			LANES = 4'h1;
		else if (width_reg == `PORT_W16)
			LANES = 4'h3;
		else if (size_reg == `SIZE_WORD || burst_reg)
			LANES = 4'hF;
		else if (size_reg == `SIZE_HALF)
			LANES = (big_reg ^ addr_reg[1]) ? 4'hC : 4'h3;
		else
			LANES = 4'h1 << bofs;
	end

	// Piece of the datum carried by the current beat
	wire [31:0] wr_piece = wdata_reg >> {(lo_reg[1:0] - addr_reg[1:0]), 3'h0};
	wire [31:0] rd_merge = (width_reg == `PORT_W32) ? ad_sync_reg :
		(width_reg == `PORT_W16) ?
			(asm_reg | ({16'h0, ad_sync_reg[15:0]} << {lo_reg[1], 4'h0})) :
			(asm_reg | ({24'h0, ad_sync_reg[7:0]} << {lo_reg[1:0], 3'h0}));
	wire last_piece = burst_reg ? (lo_reg + step == 4'h0) :
		(pieces_reg == 4'h1);
	wire word_full = (width_reg == `PORT_W32) ||
		(lo_reg[1:0] + step[1:0] == 2'h0) ||
		(!burst_reg && pieces_reg == 4'h1);

	assign REQ_READY = (state_reg == S_IDLE) && rst_seen_reg;

	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= S_IDLE;
			write_reg <= 1'b0;
			burst_reg <= 1'b0;
			miss_reg <= 1'b0;
			ifetch_reg <= 1'b0;
			big_reg <= 1'b0;
			size_reg <= 2'h0;
			width_reg <= 2'h0;
			addr_reg <= 32'h0;
			wdata_reg <= 32'h0;
			lo_reg <= 4'h0;
			pieces_reg <= 4'h0;
			asm_reg <= 32'h0;
			AD_OUT <= 32'h0;
			AD_OE <= 1'b0;
			ADDR_LO_OUT <= 4'h0;
			ALE <= 1'b0;
			DIAG <= 1'b0;
			READ_DRIVE_ENABLE <= 1'b0;
			DONE <= 1'b0;
			fifo_push <= 1'b0;
		end else begin
			DONE <= 1'b0;
			fifo_push <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				READ_DRIVE_ENABLE <= 1'b0; // R15
				AD_OE <= 1'b0;
				if (REQ_VALID && rst_seen_reg) begin
					write_reg <= REQ_WRITE;
					burst_reg <= REQ_BURST && !REQ_WRITE; // R2
					size_reg <= REQ_SIZE;
					width_reg <= PORT_WIDTH;
					big_reg <= BIG_ENDIAN;
					addr_reg <= REQ_ADDR;
					wdata_reg <= REQ_WDATA;
					miss_reg <= REQ_MISS;
					ifetch_reg <= REQ_IFETCH;
					asm_reg <= 32'h0;
					// Block reads count from zero
					lo_reg <= (REQ_BURST && !REQ_WRITE) ? 4'h0 : REQ_ADDR[3:0]; // R6
					ADDR_LO_OUT <= (REQ_BURST && !REQ_WRITE) ? 4'h0 : REQ_ADDR[3:0]; // R4
					AD_OUT <= {REQ_ADDR[31:4], 4'h0}; // R1
					AD_OE <= 1'b1;
					ALE <= 1'b1; // R11
					DIAG <= REQ_MISS && !REQ_WRITE; // R8
					state_reg <= S_ADDR;
				end
			end
			S_ADDR: begin
				pieces_reg <= datum_pieces;
				ALE <= 1'b0; // R1
				DIAG <= ifetch_reg && !write_reg; // R9
				if (write_reg) begin
					AD_OUT <= wr_piece;
					state_reg <= S_DATA;
				end else begin
					AD_OE <= 1'b0;
					state_reg <= S_TURN;
				end
			end
			S_TURN: begin
				READ_DRIVE_ENABLE <= 1'b1; // R13
				state_reg <= S_DATA;
			end
			S_DATA: begin
				if (!write_reg && cap_rise && fifo_in_ready) begin
					asm_reg <= word_full ? 32'h0 : rd_merge; // R2
					fifo_push <= word_full; // R16
					if (last_piece) begin
						READ_DRIVE_ENABLE <= 1'b0;
					end else begin
						lo_reg <= lo_reg + step; // R6
						ADDR_LO_OUT <= lo_reg + step; // R5
						pieces_reg <= pieces_reg - 4'h1;
					end
				end
				if (ack_rise) begin
					if (write_reg && !last_piece) begin
						lo_reg <= lo_reg + step; // R5
						ADDR_LO_OUT <= lo_reg + step; // R5
						pieces_reg <= pieces_reg - 4'h1;
						AD_OUT <= wdata_reg >> {(lo_reg[1:0] + step[1:0]
							- addr_reg[1:0]), 3'h0};
					end else if (write_reg || !READ_DRIVE_ENABLE) begin
						READ_DRIVE_ENABLE <= 1'b0; // R15
						AD_OE <= 1'b0;
						DIAG <= 1'b0; // R10
						DONE <= 1'b1; // R17
						state_reg <= S_IDLE;
					end
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	reg [31:0] push_data_reg;
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N)
			push_data_reg <= 32'h0;
		else if (cap_rise)
			push_data_reg <= rd_merge;
	end

	////////////////////////////////////////////////////////////////
	// Read buffer between bus and core
	rd_fifo #(
		.WIDTH(32),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_rd_fifo (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.in_data(push_data_reg),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.out_data(RD_DATA),
		.out_valid(RD_VALID),
		.out_ready(RD_READY)
	);
endmodule

// File: verification/membus_chk.sv
// Timing checker for the memory bus block
`timescale 1ns/1ps
module membus_chk (
	input wire CLK_SYS,
	input wire RESET_N,
	input wire REQ_VALID,
	input wire REQ_READY,
	input wire REQ_WRITE,
	input wire REQ_BURST,
	input wire REQ_MISS,
	input wire REQ_IFETCH,
	input wire [31:0] REQ_ADDR,
	input wire AD_OE,
	input wire [3:0] ADDR_LO_OUT,
	input wire ALE,
	input wire DIAG,
	input wire READ_DRIVE_ENABLE,
	input wire BOOT_ROM_16BIT_OPT
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (!RESET_N);
sequence rd_go; REQ_VALID && REQ_READY && !REQ_WRITE; endsequence
sequence addr_ph; ALE && AD_OE; endsequence
reg [1:0] up_reg;
always @(posedge CLK_SYS or negedge RESET_N) begin
	if (!RESET_N) up_reg <= 2'h0;
	else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
end
phase_order_a: assert property (rd_go |=> addr_ph ##1 (!ALE && !AD_OE))
	else $error("read phases out of order");
ale_one_a: assert property ($rose(ALE) |=> !ALE)
	else $error("strobe too long");
rde_release_a: assert property (READ_DRIVE_ENABLE |-> !AD_OE)
	else $error("drive enable while driving");
rde_time_a: assert property (rd_go |-> ##3 READ_DRIVE_ENABLE)
	else $error("drive enable late");
rde_idle_a: assert property (REQ_READY |-> !READ_DRIVE_ENABLE)
	else $error("drive enable in idle");
wr_no_rde_a: assert property (REQ_VALID && REQ_READY && REQ_WRITE |=> !READ_DRIVE_ENABLE[*4])
	else $error("drive enable on write");
diag_miss_a: assert property (rd_go |=> DIAG == $past(REQ_MISS))
	else $error("miss flag wrong");
diag_kind_a: assert property (rd_go |-> ##2 DIAG == $past(REQ_IFETCH, 2))
	else $error("fetch flag wrong");
burst_zero_a: assert property (rd_go ##0 REQ_BURST |=> ADDR_LO_OUT == 4'h0)
	else $error("burst count start");
exact_addr_a: assert property (rd_go ##0 !REQ_BURST |=> ADDR_LO_OUT[3:2] == $past(REQ_ADDR[3:2]))
	else $error("low address wrong");
opt_hold_a: assert property (up_reg == 2'h3 |-> $stable(BOOT_ROM_16BIT_OPT))
	else $error("option changed");
endmodule
bind membus_if membus_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
	.REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_BURST(REQ_BURST), .REQ_MISS(REQ_MISS),
	.REQ_IFETCH(REQ_IFETCH), .REQ_ADDR(REQ_ADDR), .AD_OE(AD_OE), .ADDR_LO_OUT(ADDR_LO_OUT),
	.ALE(ALE), .DIAG(DIAG), .READ_DRIVE_ENABLE(READ_DRIVE_ENABLE),
	.BOOT_ROM_16BIT_OPT(BOOT_ROM_16BIT_OPT));

// File: verification/mem_model.sv
// External memory model with address latch and data drivers
`timescale 1ns/1ps
module mem_model (
	input wire clk,
	input wire slow,
	input wire [3:0] strap,
	input wire [31:0] ad_out,
	input wire [3:0] lo_out,
	input wire lo_oe,
	input wire ale,
	input wire rde,
	output reg [31:0] ad_in,
	output wire [3:0] lo_in,
	output reg cap,
	output reg ack
);
reg [31:0] a;
// Pull straps show whenever the pins are released
assign lo_in = lo_oe ? lo_out : strap;
initial begin
	ad_in = 32'h0;
	cap = 1'b0;
	ack = 1'b0;
	forever begin
		@(negedge clk);
		if (ale) begin
			a = ad_out;
			repeat (3) @(negedge clk);
			while (rde) begin
				repeat (slow ? 5 : 1) @(negedge clk);
				a[3:0] = lo_out;
				ad_in <= {~a[15:0], a[15:0]};
				@(negedge clk);
				cap <= 1'b1;
				repeat (2) @(negedge clk);
				cap <= 1'b0;
				repeat (4) @(negedge clk);
				ad_in <= ~ad_in;
			end
			ack <= 1'b1;
			repeat (2) @(negedge clk);
			ack <= 1'b0;
		end
	end
end
endmodule

// File: verification/tb.sv
// Self-checking bench for the memory bus block
`timescale 1ns/1ps
module tb;
reg CLK_SYS = 1'b0, RESET_N = 1'b0, REQ_VALID = 1'b0, REQ_WRITE = 1'b0, REQ_BURST = 1'b0;
reg REQ_MISS = 1'b0, REQ_IFETCH = 1'b0, BIG_ENDIAN = 1'b0, RD_READY = 1'b0, slow = 1'b0;
reg [1:0] REQ_SIZE = 2'h2, PORT_WIDTH = 2'h0;
reg [3:0] strap = 4'hA;
reg [31:0] REQ_ADDR = 32'h0, REQ_WDATA = 32'h0;
wire REQ_READY, RD_VALID, DONE, AD_OE, ADDR_LO_OE, ALE, DIAG, READ_DRIVE_ENABLE, CAP, ACK;
wire O16, O8, ORH, OEH;
wire [31:0] RD_DATA, AD_IN, AD_OUT;
wire [3:0] ADDR_LO_IN, ADDR_LO_OUT, LANES;
integer bad_count = 0, n_checks = 0, i, k;
always #50 CLK_SYS = ~CLK_SYS;
membus_if u_dut (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
	.REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_BURST(REQ_BURST), .REQ_SIZE(REQ_SIZE),
	.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_MISS(REQ_MISS), .REQ_IFETCH(REQ_IFETCH),
	.PORT_WIDTH(PORT_WIDTH), .BIG_ENDIAN(BIG_ENDIAN), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
	.RD_READY(RD_READY), .DONE(DONE), .AD_IN(AD_IN), .AD_OUT(AD_OUT), .AD_OE(AD_OE),
	.ADDR_LO_IN(ADDR_LO_IN), .ADDR_LO_OUT(ADDR_LO_OUT), .ADDR_LO_OE(ADDR_LO_OE), .ALE(ALE),
	.DIAG(DIAG), .READ_DRIVE_ENABLE(READ_DRIVE_ENABLE), .LANES(LANES),
	.READ_BUF_CAPTURE(CAP), .ACK(ACK), .BOOT_ROM_16BIT_OPT(O16), .BOOT_ROM_8BIT_OPT(O8),
	.RESERVED_HIGH_OPT(ORH), .EXTENDED_ADDR_HOLD_OPT(OEH));
mem_model u_mem (.clk(CLK_SYS), .slow(slow), .strap(strap), .ad_out(AD_OUT),
	.lo_out(ADDR_LO_OUT), .lo_oe(ADDR_LO_OE), .ale(ALE), .rde(READ_DRIVE_ENABLE),
	.ad_in(AD_IN), .lo_in(ADDR_LO_IN), .cap(CAP), .ack(ACK));
function [31:0] mw(input [31:0] a);
	mw = {~a[15:0], a[15:0]};
endfunction
task complete_run;
	if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
	else $display("STATUS NOT OK");
	$finish;
endtask
task chk(input c, input [8*8-1:0] m);
	n_checks = n_checks + 1;
	if (!c) begin
		bad_count = bad_count + 1;
		$display("mismatch at %0t: %0s", $time, m);
	end
endtask
task req(input w, input b, input [1:0] s, input [31:0] a, input [31:0] d, input m, input f);
	@(posedge CLK_SYS);
	{REQ_VALID, REQ_WRITE, REQ_BURST, REQ_SIZE} <= {1'b1, w, b, s};
	{REQ_ADDR, REQ_WDATA, REQ_MISS, REQ_IFETCH} <= {a, d, m, f};
	@(negedge CLK_SYS);
	for (k = 0; k < 50 && REQ_READY !== 1'b1; k = k + 1) @(negedge CLK_SYS);
	if (k == 50) begin
		chk(1'b0, "ready");
		complete_run;
	end
	@(posedge CLK_SYS);
	REQ_VALID <= 1'b0;
endtask
task wait_done;
	for (k = 0; k < 300 && DONE !== 1'b1; k = k + 1) @(negedge CLK_SYS);
	if (k == 300) begin
		chk(1'b0, "timeout");
		complete_run;
	end
endtask
task pop(input [31:0] e);
	@(negedge CLK_SYS);
	for (k = 0; k < 300 && RD_VALID !== 1'b1; k = k + 1) @(negedge CLK_SYS);
	if (k == 300) begin
		chk(1'b0, "timeout");
		complete_run;
	end
	chk(RD_DATA === e, "data");
	@(posedge CLK_SYS);
	RD_READY <= 1'b1;
	@(posedge CLK_SYS);
	RD_READY <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////////
task t_reset(input [3:0] s);
	@(posedge CLK_SYS);
	RESET_N <= 1'b0;
	strap <= s;
	@(posedge CLK_SYS);
	@(negedge CLK_SYS);
	chk(ADDR_LO_OE === 1'b0, "pins oe");
	@(posedge CLK_SYS);
	RESET_N <= 1'b1;
	repeat (4) @(negedge CLK_SYS);
	chk({OEH, ORH, O8, O16} === s, "options");
	chk(ADDR_LO_OE === 1'b1, "pins on");
endtask
task t_read(input m, input f);
	req(1'b0, 1'b0, 2'h2, 32'h00001238, 32'h0, m, f);
	@(negedge CLK_SYS);
	chk(ADDR_LO_OE === 1'b1, "pins oe");
	chk(ALE === 1'b1, "strobe");
	chk(DIAG === m, "miss");
	@(negedge CLK_SYS);
	chk(DIAG === f, "fetch");
	chk(AD_OE === 1'b0, "release");
	wait_done;
	pop(mw(32'h00001238));
endtask
task t_burst;
	req(1'b0, 1'b1, 2'h2, 32'h00002340, 32'h0, 1'b1, 1'b1);
	wait_done;
	req(1'b0, 1'b1, 2'h2, 32'h00005670, 32'h0, 1'b1, 1'b0);
	wait_done;
	for (i = 0; i < 8; i = i + 1) pop(mw((i < 4 ? 32'h2340 : 32'h5670) + 4 * (i % 4)));
	@(negedge CLK_SYS);
	chk(RD_VALID === 1'b0, "empty");
endtask
task t_narrow;
	@(posedge CLK_SYS);
	PORT_WIDTH <= 2'h2;
	req(1'b0, 1'b0, 2'h2, 32'h00001238, 32'h0, 1'b0, 1'b0);
	wait_done;
	pop(32'h3B3A3938);
	@(posedge CLK_SYS);
	PORT_WIDTH <= 2'h1;
	req(1'b0, 1'b1, 2'h2, 32'h00002340, 32'h0, 1'b1, 1'b0);
	wait_done;
	for (i = 0; i < 4; i = i + 1) pop(32'h23422340 + 32'h00040004 * i);
	@(posedge CLK_SYS);
	PORT_WIDTH <= 2'h0;
endtask
task t_write(input be, input [1:0] s, input [3:0] lanes);
	@(posedge CLK_SYS);
	BIG_ENDIAN <= be;
	req(1'b1, 1'b0, s, 32'h00003450, 32'hC3A5965A, 1'b0, 1'b0);
	@(posedge CLK_SYS);
	@(negedge CLK_SYS);
	chk(LANES === lanes, "lanes");
	chk(s != 2'h2 || AD_OUT === 32'hC3A5965A, "wdata");
	wait_done;
endtask
initial begin
	t_reset(4'hA);
	t_read(1'b1, 1'b0);
	slow <= 1'b1;
	t_read(1'b0, 1'b1);
	t_burst;
	slow <= 1'b0;
	t_narrow;
	t_write(1'b0, 2'h0, 4'h1);
	t_write(1'b1, 2'h0, 4'h8);
	t_write(1'b0, 2'h1, 4'h3);
	t_write(1'b1, 2'h1, 4'hC);
	t_write(1'b0, 2'h2, 4'hF);
	t_reset(4'h5);
	t_read(1'b1, 1'b1);
	complete_run;
end
endmodule
